// ### rtl/ectsy_cfg.svh
// Purpose: Constants for the external count clock synchroniser
// Assumes: One REF_CLK period stands for one oscillator period
// Notes: Definitions only
`ifndef ECTSY_CFG_SVH
`define ECTSY_CFG_SVH

// Ripple prescaler width and ratio select width
`define ECTSY_PRESC_W 8
`define ECTSY_RATIO_W 3

// Reset values
`define ECTSY_PRESC_RST 8'h00
`define ECTSY_LEVEL_RST 1'h0
`define ECTSY_PIN_RST 1'h0
`define ECTSY_INC_RST 1'h0

// Far side input timing, in ns (held by the external source)
`define ECTSY_UNDIV_RC_NS 20
`define ECTSY_DIV_RC_NS 40

`endif

// ### rtl/ectsy_phase_gen.sv
// Purpose: Internal four-phase sequencer with sample strobes
// Assumes: Each phase lasts one REF_CLK period
// Notes: Strobes are registered
`timescale 1ns/10ps
module ectsy_phase_gen
  import ectsy_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Strobes out
  ectsy_phase_if.gen ph
);

  ectsy_phase_t phase_q;
  ectsy_phase_t phase_d;
  logic two_q;
  logic four_q;

  always_comb
  begin
    case (phase_q)
      PHASE_ONE: phase_d = PHASE_TWO;
      PHASE_TWO: phase_d = PHASE_THREE;
      PHASE_THREE: phase_d = PHASE_FOUR;
      PHASE_FOUR: phase_d = PHASE_ONE;
      default: phase_d = PHASE_ONE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_q <= PHASE_ONE;
      two_q <= 1'h0;
      four_q <= 1'h0;
    end
    else
    begin
      phase_q <= phase_d;
      two_q <= (phase_d == PHASE_TWO);
      four_q <= (phase_d == PHASE_FOUR);
    end
  end

  assign ph.phase_two_sample = two_q;
  assign ph.phase_four_sample = four_q;

endmodule

// ### rtl/ectsy_phase_if.sv
// Purpose: Phase sample strobes between phase generator and synchroniser
// Assumes: Single REF_CLK domain
// Notes: Strobes are one-cycle pulses
`timescale 1ns/10ps
interface ectsy_phase_if;
  logic phase_two_sample;
  logic phase_four_sample;

  modport gen
  (
    output phase_two_sample,
    output phase_four_sample
  );

  modport use_side
  (
    input phase_two_sample,
    input phase_four_sample
  );
endinterface

// ### rtl/ectsy_pkg.sv
// Purpose: Types for the external count clock synchroniser
// Assumes: Included after ectsy_cfg.svh
// Notes: Four internal phases per instruction cycle
package ectsy_pkg;

  typedef enum logic [1:0] {PHASE_ONE, PHASE_TWO, PHASE_THREE, PHASE_FOUR} ectsy_phase_t;

endpackage

// ### rtl/ectsy_sync.sv
// Purpose: Synchroniser front end for an 8-bit timer on an external count clock
// Assumes: Pin is asynchronous to REF_CLK; timer register lives elsewhere
//   Prescaler controls come from REF_CLK logic and are not synchronised
// Notes: Ripple prescaler is modelled synchronously on REF_CLK
//   Prescaler free-runs and is not cleared when it is reassigned
//   Changing ratio or assignment in flight may add or lose one count
//
// How it works
// R01: Without the prescaler the pin level itself is the count source ahead of synchronisation.
// R02: The count source is sampled on the phase-two and phase-four strobes of every instruction cycle.
// R03: The external source holds the pin high and low each for at least two oscillator periods plus 20 ns.
// R04: With the prescaler the pin is divided by a binary counter whose chosen bit is a symmetrical output.
// R05: With the prescaler the pin period is at least four oscillator periods plus 40 ns over the ratio.
// R06: The timer increment is issued only after the edge has passed the phase sampling.
// R07: One increment is issued per sampled rising transition and none while the level stays high.
`timescale 1ns/10ps
`include "ectsy_cfg.svh"
module ectsy_sync
  import ectsy_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // External count pin
  input wire logic EXT_COUNT_CLOCK_PIN,
  // Prescaler control
  input wire logic PRESC_ASSIGN,
  input wire logic [`ECTSY_RATIO_W-1:0] PRESC_RATIO,
  // To the timer
  output logic COUNT_INC,
  output logic SAMPLED_LEVEL
);

  // Strobes from the phase sequencer
  ectsy_phase_if ph_if ();

  // Pin synchroniser stages
  logic pin_meta_q;
  logic pin_meta_d;
  logic pin_sync_q;
  logic pin_sync_d;
  logic pin_prev_q;
  logic pin_prev_d;

  // Prescaler state
  logic [`ECTSY_PRESC_W-1:0] presc_q;
  logic [`ECTSY_PRESC_W-1:0] presc_d;

  // Ripple stage toggles
  wire ripple0;
  wire ripple1;
  wire ripple2;
  wire ripple3;
  wire ripple4;
  wire ripple5;
  wire ripple6;
  wire ripple7;

  // Sampled level and increment
  logic level_q;
  logic level_d;
  logic inc_q;
  logic inc_d;

  // Strobe decode
  wire strobe_two;
  wire strobe_four;
  wire sample_now;

  // Count path decode
  wire pin_rise;
  wire presc_out;
  wire count_src;
  wire src_rise;

  // Edge test shared by the pin and the sampled source
  function automatic logic rise(input logic prev, input logic cur);
    rise = cur & ~prev;
  endfunction

  // Bit k of the counter divides the pin by 2 to the k+1
  function automatic logic tap_bit(input logic [`ECTSY_PRESC_W-1:0] cnt, input logic [`ECTSY_RATIO_W-1:0] sel);
    case (sel)
      3'h0: tap_bit = cnt[0];
      3'h1: tap_bit = cnt[1];
      3'h2: tap_bit = cnt[2];
      3'h3: tap_bit = cnt[3];
      3'h4: tap_bit = cnt[4];
      3'h5: tap_bit = cnt[5];
      3'h6: tap_bit = cnt[6];
      3'h7: tap_bit = cnt[7];
      default: tap_bit = cnt[0];
    endcase
  endfunction

  // Four-phase sequencer, one REF_CLK per phase
  ectsy_phase_gen u_phase
  (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .ph(ph_if.gen)
  );

  // Two flops settle the pin before any decode sees it
  // Only the second stage reads the first
  assign pin_meta_d = EXT_COUNT_CLOCK_PIN;
  assign pin_sync_d = pin_meta_q;
  assign pin_prev_d = pin_sync_q;
  assign pin_rise = rise(pin_prev_q, pin_sync_q);

  // R04: ripple divider stages
  assign ripple0 = pin_rise;
  assign ripple1 = ripple0 & presc_q[0];
  assign ripple2 = ripple1 & presc_q[1];
  assign ripple3 = ripple2 & presc_q[2];
  assign ripple4 = ripple3 & presc_q[3];
  assign ripple5 = ripple4 & presc_q[4];
  assign ripple6 = ripple5 & presc_q[5];
  assign ripple7 = ripple6 & presc_q[6];
  assign presc_d = presc_q ^ {ripple7, ripple6, ripple5, ripple4, ripple3, ripple2, ripple1, ripple0};

  // R04: symmetrical tap
  assign presc_out = tap_bit(presc_q, PRESC_RATIO);

  // R01: pin when unassigned
  assign count_src = PRESC_ASSIGN ? presc_out : pin_sync_q;

  // R02: phase two and four
  // Strobes are two cycles apart; a shorter level may be missed
  assign strobe_two = ph_if.phase_two_sample;
  assign strobe_four = ph_if.phase_four_sample;
  assign sample_now = strobe_two | strobe_four;
  assign level_d = sample_now ? count_src : level_q;

  // R07: one pulse per rise
  // A level that stays high gives no further pulse
  assign src_rise = rise(level_q, count_src);
  assign inc_d = sample_now & src_rise;

  // First stage, may go metastable
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pin_meta_q <= `ECTSY_PIN_RST;
    end
    else
    begin
      pin_meta_q <= pin_meta_d;
    end
  end

  // Second stage, settled pin level
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pin_sync_q <= `ECTSY_PIN_RST;
    end
    else
    begin
      pin_sync_q <= pin_sync_d;
    end
  end

  // Previous level; resets to the idle pin level
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pin_prev_q <= `ECTSY_PIN_RST;
    end
    else
    begin
      pin_prev_q <= pin_prev_d;
    end
  end

  // Prescaler runs even when unassigned
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      presc_q <= `ECTSY_PRESC_RST;
    end
    else
    begin
      presc_q <= presc_d;
    end
  end

  // R06: level moves on strobes
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      level_q <= `ECTSY_LEVEL_RST;
    end
    else
    begin
      level_q <= level_d;
    end
  end

  // R06: increment after sampling
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      inc_q <= `ECTSY_INC_RST;
    end
    else
    begin
      inc_q <= inc_d;
    end
  end

  // Outputs straight from flops
  assign COUNT_INC = inc_q;
  assign SAMPLED_LEVEL = level_q;

endmodule

// ### test/ectsy_ext_src.sv
// Purpose: External count source
// Assumes: Bench calls burst
// Notes: Pin rests low
`timescale 1ns/10ps
module ectsy_ext_src (
  // Pin
  output logic pin
);
  initial pin = 1'b0;
  task automatic burst(input int n, input int hi_ns);
    repeat (n)
    begin
      pin = 1'b1;
      #(hi_ns);
      pin = 1'b0;
      #(hi_ns);
    end
  endtask
endmodule

// ### test/ectsy_sync_assertions.sv
// Purpose: Port checks for ectsy_sync
// Assumes: Bound to the top
// Notes: 8 held cycles settle a sample
`timescale 1ns/10ps
module ectsy_chk (
  // Watched ports
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic EXT_COUNT_CLOCK_PIN,
  input wire logic PRESC_ASSIGN,
  input wire logic COUNT_INC,
  input wire logic SAMPLED_LEVEL
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  a_inc_single: assert property (COUNT_INC |=> !COUNT_INC) else $error("long inc");
  a_inc_rise: assert property (COUNT_INC |-> SAMPLED_LEVEL && !$past(SAMPLED_LEVEL)) else $error("bad inc");
  a_rise_count: assert property ($rose(SAMPLED_LEVEL) |-> COUNT_INC) else $error("lost inc");
  a_strobe_gap: assert property ($changed(SAMPLED_LEVEL) |=> $stable(SAMPLED_LEVEL)) else $error("gap");
  a_pin_high: assert property ((!PRESC_ASSIGN && EXT_COUNT_CLOCK_PIN)[*8] |-> SAMPLED_LEVEL) else $error("miss");
endmodule
bind ectsy_sync ectsy_chk i_chk (.REF_CLK(REF_CLK), .RST_B(RST_B), .EXT_COUNT_CLOCK_PIN(EXT_COUNT_CLOCK_PIN),
  .PRESC_ASSIGN(PRESC_ASSIGN), .COUNT_INC(COUNT_INC), .SAMPLED_LEVEL(SAMPLED_LEVEL));

// ### test/ext_clock_timer_sync_test.sv
// Purpose: Bench for ectsy_sync
// Assumes: 32 ns source levels, so pin edges fall on falling clock edges
// Notes: Reset clears the prescaler
`timescale 1ns/10ps
module ext_clock_timer_sync_test;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic presc_assign = 1'b0;
  logic [2:0] presc_ratio = 3'h0;
  logic pin;
  logic count_inc;
  logic sampled_level;
  int n_fail = 0;
  int checked = 0;
  int n_inc = 0;
  int cyc = 0;
  int lat = 0;
  int rows [9][4] = '{'{0,0,5,5}, '{1,0,4,2}, '{1,1,4,1}, '{1,2,8,1}, '{1,3,16,1}, '{1,4,32,1}, '{1,5,64,1},
    '{1,6,128,1}, '{1,7,256,1}};
  always #2 ref_clk = ~ref_clk;
  ectsy_sync i_ectsy_sync (.REF_CLK(ref_clk), .RST_B(rst_b), .EXT_COUNT_CLOCK_PIN(pin),
    .PRESC_ASSIGN(presc_assign), .PRESC_RATIO(presc_ratio), .COUNT_INC(count_inc), .SAMPLED_LEVEL(sampled_level));
  ectsy_ext_src i_ectsy_ext_src (.pin(pin));
  task results;
    $display("fails %0d checks %0d", n_fail, checked);
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %0d not %0d", $time, seen, exp);
    end
  endtask
  task rst;
    rst_b = 1'b0;
    repeat (3) @(negedge ref_clk);
    rst_b = 1'b1;
    n_inc = 0;
  endtask
  // Hang guard well above the 8.4k cycle run
  always @(posedge ref_clk)
  begin
    cyc++;
    if (count_inc === 1'b1)
      n_inc++;
    if (cyc == 20000)
    begin
      n_fail++;
      results;
    end
  end
  initial
  begin
    foreach (rows[i])
    begin
      presc_assign = 1'(rows[i][0]);
      presc_ratio = 3'(rows[i][1]);
      rst;
      i_ectsy_ext_src.burst(rows[i][2], 32);
      repeat (8) @(negedge ref_clk);
      chk(16'(n_inc), 16'(rows[i][3]));
    end
    presc_assign = 1'b0;
    rst;
    fork
      i_ectsy_ext_src.burst(1, 400);
    join_none
    while (count_inc !== 1'b1 && lat < 10)
    begin
      @(negedge ref_clk);
      lat++;
    end
    chk(16'(lat >= 3 && lat <= 5), 16'h1);
    repeat (56) @(negedge ref_clk);
    chk(16'(n_inc), 16'h1);
    chk(16'(sampled_level), 16'h1);
    rst_b = 1'b0;
    @(negedge ref_clk);
    chk(16'({count_inc, sampled_level}), 16'h0);
    results;
  end
endmodule
